// ==== hdl/bdm_defines.svh ====
`ifndef BDM_DEFINES_SVH
`define BDM_DEFINES_SVH

// byte address layout of the internal data memory
`define BDM_DMSEL_BIT 31
`define BDM_BLK_BIT 18
`define BDM_SUB_BIT 17
`define BDM_ROW_HI 16
`define BDM_ROW_LO 8
`define BDM_COL_HI 7
`define BDM_COL_LO 3
`define BDM_BNK_HI 2
`define BDM_BNK_LO 1
`define BDM_BYTE_BIT 0

// organisation
`define BDM_NUM_BLOCKS 2
`define BDM_SUBS_PER_BLOCK 2
`define BDM_BANKS_PER_SUB 4
`define BDM_NUM_BANKS 16
`define BDM_BANK_W 16
`define BDM_ROW_W 9
`define BDM_COL_W 5
`define BDM_BID_W 4
`define BDM_ADDR_W 32

// reset values
`define BDM_RST_DATA 16'h0000

`endif

// ==== hdl/bdm_pkg.sv ====
`default_nettype none
`include "bdm_defines.svh"

package bdm_pkg;

	// decoded fields of one byte address
	typedef struct packed {
		logic dm;
		logic [`BDM_BID_W-1:0] bank;
		logic [`BDM_ROW_W-1:0] row;
		logic [`BDM_COL_W-1:0] col;
		logic lane;
	} bdm_dec_s;

	// which requester owns the memory in a cycle
	typedef enum logic [2:0] {
		BDM_SRC_NONE = 3'b001,
		BDM_SRC_CPU = 3'b010,
		BDM_SRC_DMA = 3'b100
	} bdm_src_e;

	typedef struct packed {
		logic pw_valid;
		logic [`BDM_BID_W-1:0] pw_bank;
		logic [`BDM_ROW_W-1:0] pw_row;
		logic [`BDM_COL_W-1:0] pw_col;
		logic cpu_rvalid;
		logic dma_rvalid;
		logic cpu_err;
		logic dma_err;
		logic stall;
		logic [`BDM_BANK_W-1:0] rdata;
	} bdm_state_s;

endpackage

`default_nettype wire

// ==== hdl/bdm_bank.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "bdm_defines.svh"

module bdm_bank #(
	parameter int ROW_W = `BDM_ROW_W,
	parameter int COL_W = `BDM_COL_W,
	parameter int DW = `BDM_BANK_W
) (
	input wire logic mclk,
	input wire logic we,
	input wire logic [1:0] be,
	input wire logic [ROW_W+COL_W-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);

	// one 16-bit bank, two byte lanes; contents are not reset, as in real ram
	logic [DW-1:0] mem [0:(1<<(ROW_W+COL_W))-1];

	// combinational read so the front end can register the result in the access cycle
	assign rdata = mem[addr];

	always_ff @(posedge mclk) begin
		if (we && be[0]) begin
			mem[addr][DW/2-1:0] <= wdata[DW/2-1:0];
		end
		if (we && be[1]) begin
			mem[addr][DW-1:DW/2] <= wdata[DW-1:DW/2];
		end
	end

endmodule

`default_nettype wire

// ==== hdl/bdm_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "bdm_defines.svh"

// Operation
// - sixteen 16-bit banks, two blocks, two subblocks
// - decode select, block, subblock, row, column, bank
// - hazard only on back-to-back write then read
// - hazard needs same bank and same column
// - hazard needs differing row field
// - unguarded pair may misread a stored bit
// - every cpu and dma pairing is guarded
module bdm_top
	import bdm_pkg::*;
#(
	parameter int NBANK = `BDM_NUM_BANKS,
	parameter int DW = `BDM_BANK_W
) (
	input wire logic mclk,
	input wire logic nrst,
	// cpu requester
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [`BDM_ADDR_W-1:0] cpu_addr,
	input wire logic [1:0] cpu_be,
	input wire logic [DW-1:0] cpu_wdata,
	output logic cpu_ready,
	output logic cpu_rvalid,
	output logic [DW-1:0] cpu_rdata,
	output logic cpu_err,
	// dma requester
	input wire logic dma_req,
	input wire logic dma_we,
	input wire logic [`BDM_ADDR_W-1:0] dma_addr,
	input wire logic [1:0] dma_be,
	input wire logic [DW-1:0] dma_wdata,
	output logic dma_ready,
	output logic dma_rvalid,
	output logic [DW-1:0] dma_rdata,
	output logic dma_err,
	// guard status
	output logic raw_stall
);

	// block, then subblock, then bank within the subblock: two times two times four banks
	function automatic logic [`BDM_BID_W-1:0] bdm_bank_id(input logic blk, input logic sub,
		input logic [`BDM_BNK_HI-`BDM_BNK_LO:0] bnk);
		return {blk, sub, bnk};
	endfunction

	// reserved bits 30..19 are ignored
	// lane bit is decoded but unused; the byte enables pick the lanes
	function automatic bdm_dec_s bdm_decode(input logic [`BDM_ADDR_W-1:0] a);
		bdm_dec_s d;
		d.dm = a[`BDM_DMSEL_BIT];
		d.bank = bdm_bank_id(a[`BDM_BLK_BIT], a[`BDM_SUB_BIT], a[`BDM_BNK_HI:`BDM_BNK_LO]);
		d.row = a[`BDM_ROW_HI:`BDM_ROW_LO];
		d.col = a[`BDM_COL_HI:`BDM_COL_LO];
		d.lane = a[`BDM_BYTE_BIT];
		return d;
	endfunction

	// block and subblock sit in the bank id, so a different block never matches
	function automatic logic bdm_raw_risk(input bdm_state_s s, input bdm_dec_s d);
		logic same_bank;
		logic same_col;
		logic same_place;
		logic new_row;
		same_bank = (s.pw_bank == d.bank);
		same_col = (s.pw_col == d.col);
		same_place = same_bank && same_col;
		new_row = (s.pw_row != d.row);
		return s.pw_valid && same_place && new_row;
	endfunction

	bdm_state_s s_reg;
	bdm_state_s s_next;
	bdm_src_e src;
	bdm_dec_s dec;
	logic sel_we;
	logic [`BDM_ADDR_W-1:0] sel_addr;
	logic [1:0] sel_be;
	logic [DW-1:0] sel_wdata;
	logic hazard;
	logic go;
	logic [DW-1:0] bank_rdata [0:NBANK-1];
	logic [`BDM_ROW_W+`BDM_COL_W-1:0] bank_addr;

	// per-access qualifiers shared by grant, write enable and read capture
	logic cpu_win;
	logic dma_win;
	logic rd_dm;
	logic wr_go;
	logic [DW-1:0] rd_word;

	// fixed priority: a cpu that requests every cycle starves the dma
	always_comb begin
		src = BDM_SRC_NONE;
		sel_we = 1'b0;
		sel_addr = '0;
		sel_be = 2'b00;
		sel_wdata = '0;
		if (cpu_req) begin
			src = BDM_SRC_CPU;
			sel_we = cpu_we;
			sel_addr = cpu_addr;
			sel_be = cpu_be;
			sel_wdata = cpu_wdata;
		end else if (dma_req) begin
			src = BDM_SRC_DMA;
			sel_we = dma_we;
			sel_addr = dma_addr;
			sel_be = dma_be;
			sel_wdata = dma_wdata;
		end
	end

	assign dec = bdm_decode(sel_addr);
	// row above column gives the word inside one bank
	assign bank_addr = {dec.row, dec.col};

	// grant and answer steering by winning source
	assign cpu_win = (src == BDM_SRC_CPU);
	assign dma_win = (src == BDM_SRC_DMA);
	assign rd_dm = (src != BDM_SRC_NONE) && !sel_we && dec.dm;

	// only the write of the cycle just before counts: one dead cycle is all the ram needs,
	// so a read after an idle or stalled cycle goes through at once
	// the previous write is kept whoever issued it, so all source pairings are caught
	assign hazard = rd_dm && bdm_raw_risk(s_reg, dec);
	// a stalled read becomes the dead cycle the ram needs; nothing else is granted
	assign go = (src != BDM_SRC_NONE) && !hazard;
	assign wr_go = go && sel_we && dec.dm;

	assign cpu_ready = go && cpu_win;
	assign dma_ready = go && dma_win;

	// one ram per bank; only the addressed bank sees the write
	genvar gi;
	generate
		for (gi = 0; gi < NBANK; gi++) begin : g_bank
			logic bank_we;
			assign bank_we = wr_go && (dec.bank == `BDM_BID_W'(gi));
			bdm_bank #(
				.ROW_W(`BDM_ROW_W),
				.COL_W(`BDM_COL_W),
				.DW(DW)
			) u_bank (
				.mclk(mclk),
				.we(bank_we),
				.be(sel_be),
				.addr(bank_addr),
				.wdata(sel_wdata),
				.rdata(bank_rdata[gi])
			);
		end
	endgenerate

	// one read port for both requesters; the arbiter keeps it to one access a cycle
	assign rd_word = bank_rdata[dec.bank];

	// state update: err outside data memory, the last write kept for the guard,
	// and the read word captured in its access cycle
	always_comb begin
		s_next = s_reg;
		s_next.pw_valid = 1'b0;
		s_next.cpu_rvalid = 1'b0;
		s_next.dma_rvalid = 1'b0;
		s_next.cpu_err = 1'b0;
		s_next.dma_err = 1'b0;
		s_next.stall = hazard;
		if (go) begin
			if (!dec.dm) begin
				// outside data memory: write dropped, read answered with error only
				s_next.cpu_err = cpu_win;
				s_next.dma_err = dma_win;
			end else if (sel_we) begin
				s_next.pw_valid = 1'b1;
				s_next.pw_bank = dec.bank;
				s_next.pw_row = dec.row;
				s_next.pw_col = dec.col;
			end else begin
				// guarded reads never follow a risky write, so stored data is returned intact
				s_next.rdata = rd_word;
				s_next.cpu_rvalid = cpu_win;
				s_next.dma_rvalid = dma_win;
			end
		end
	end

	// synchronous reset; ram contents stay as they are
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s_reg.pw_valid <= 1'b0;
			s_reg.pw_bank <= '0;
			s_reg.pw_row <= '0;
			s_reg.pw_col <= '0;
			s_reg.cpu_rvalid <= 1'b0;
			s_reg.dma_rvalid <= 1'b0;
			s_reg.cpu_err <= 1'b0;
			s_reg.dma_err <= 1'b0;
			s_reg.stall <= 1'b0;
			s_reg.rdata <= `BDM_RST_DATA;
		end else begin
			s_reg <= s_next;
		end
	end

	// requesters need not keep the idle cycle themselves; the stall supplies it
	assign raw_stall = s_reg.stall;
	assign cpu_rvalid = s_reg.cpu_rvalid;
	assign dma_rvalid = s_reg.dma_rvalid;
	// both requesters see the one read register; rvalid says whose word it is
	assign cpu_rdata = s_reg.rdata;
	assign dma_rdata = s_reg.rdata;
	assign cpu_err = s_reg.cpu_err;
	assign dma_err = s_reg.dma_err;

endmodule

`default_nettype wire

// ==== dv/bdm_req.sv ====
`timescale 1ns/1ns
`default_nettype none
module bdm_req (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ready,
	output logic req,
	output logic we,
	output logic [31:0] addr,
	output logic [1:0] be,
	output logic [15:0] wdata
);
	logic w;
	initial {req, we, addr, be, wdata} = '0;
	// narrow address set so row-only changes come often; one access in eight misses data memory
	always @(posedge mclk)
		if (!nrst || !req || ready) begin
			w = 1'($urandom);
			req <= nrst && $urandom % 4 != 0;
			we <= w;
			be <= 2'($urandom % 3 + 1);
			wdata <= 16'($urandom);
			addr <= {$urandom % 8 != 0, 12'h000, 2'($urandom), 7'h00, 2'($urandom), 4'h0, 1'($urandom),
				2'($urandom), 1'b0};
		end
endmodule
`default_nettype wire

// ==== dv/bdm_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module bdm_monitor (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [31:0] cpu_addr,
	input wire logic cpu_ready,
	input wire logic cpu_rvalid,
	input wire logic cpu_err,
	input wire logic dma_req,
	input wire logic dma_we,
	input wire logic [31:0] dma_addr,
	input wire logic dma_ready,
	input wire logic dma_rvalid,
	input wire logic raw_stall
);
	logic pw_reg;
	logic [31:0] pa_reg;
	logic [31:0] ra;
	logic hz;
	assign ra = cpu_req ? cpu_addr : dma_addr;
	assign hz = pw_reg && ra[31] && (cpu_req ? !cpu_we : dma_req && !dma_we) && ra[18:17] == pa_reg[18:17]
		&& ra[7:1] == pa_reg[7:1] && ra[16:8] != pa_reg[16:8];
	always_ff @(posedge mclk) begin
		pw_reg <= nrst && (cpu_ready ? cpu_we && cpu_addr[31] : dma_ready && dma_we && dma_addr[31]);
		pa_reg <= cpu_ready ? cpu_addr : dma_addr;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	AST_HOLD: assert property (hz |-> !cpu_ready && !dma_ready ##1 raw_stall) else $error("no hold");
	AST_GRANT: assert property (cpu_req && !hz |-> cpu_ready) else $error("cpu not granted");
	AST_PRIO: assert property (dma_ready |-> !cpu_req && !hz) else $error("bad dma grant");
	AST_NOSTALL: assert property (!hz |=> !raw_stall) else $error("stray stall");
	AST_CRV: assert property (cpu_ready && !cpu_we && cpu_addr[31] |=> cpu_rvalid) else $error("no rvalid");
	AST_DRV: assert property (dma_ready && !dma_we && dma_addr[31] |=> dma_rvalid) else $error("no rvalid");
	AST_ERR: assert property (cpu_ready && !cpu_addr[31] |=> cpu_err) else $error("no err");
	AST_NORV: assert property (!(cpu_ready && !cpu_we) |=> !cpu_rvalid) else $error("stray rvalid");
	cover property (hz);
	cover property (dma_ready && !dma_we);
	cover property (cpu_err);
	cover property (cpu_ready && cpu_we ##1 dma_ready && !dma_we);
endmodule
bind bdm_top bdm_monitor u_mon (.mclk(mclk), .nrst(nrst), .cpu_req(cpu_req), .cpu_we(cpu_we),
	.cpu_addr(cpu_addr), .cpu_ready(cpu_ready), .cpu_rvalid(cpu_rvalid), .cpu_err(cpu_err), .dma_req(dma_req),
	.dma_we(dma_we), .dma_addr(dma_addr), .dma_ready(dma_ready), .dma_rvalid(dma_rvalid), .raw_stall(raw_stall));
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic mclk = 0;
	logic nrst = 0;
	logic cpu_req, cpu_we, cpu_ready, cpu_rvalid, cpu_err, dma_req, dma_we, dma_ready, dma_rvalid, dma_err;
	logic raw_stall, hz, gc, gd, pw, phz, pce, pde, pcr, pdr;
	logic [31:0] cpu_addr, dma_addr, pa, ra;
	logic [1:0] cpu_be, dma_be;
	logic [15:0] cpu_wdata, dma_wdata, cpu_rdata, dma_rdata, old, ecd, edd;
	logic [15:0] mem [int];
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	bdm_top DUT (.mclk(mclk), .nrst(nrst), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
		.cpu_be(cpu_be), .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready), .cpu_rvalid(cpu_rvalid),
		.cpu_rdata(cpu_rdata), .cpu_err(cpu_err), .dma_req(dma_req), .dma_we(dma_we), .dma_addr(dma_addr),
		.dma_be(dma_be), .dma_wdata(dma_wdata), .dma_ready(dma_ready), .dma_rvalid(dma_rvalid),
		.dma_rdata(dma_rdata), .dma_err(dma_err), .raw_stall(raw_stall));
	bdm_req u_cpu (.mclk(mclk), .nrst(nrst), .ready(cpu_ready), .req(cpu_req), .we(cpu_we), .addr(cpu_addr),
		.be(cpu_be), .wdata(cpu_wdata));
	bdm_req u_dma (.mclk(mclk), .nrst(nrst), .ready(dma_ready), .req(dma_req), .we(dma_we), .addr(dma_addr),
		.be(dma_be), .wdata(dma_wdata));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		if (n_fail == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// word key drops the byte bit; lanes come from be
	task automatic acc(input logic w, input logic [31:0] a, input logic [1:0] b, input logic [15:0] d,
		output logic [15:0] e);
		int k = a[18:1];
		old = mem.exists(k) ? mem[k] : 'x;
		e = old;
		if (w && a[31]) begin
			pa = a;
			pw = 1;
			mem[k] = {b[1] ? d[15:8] : old[15:8], b[0] ? d[7:0] : old[7:0]};
		end
	endtask
	assign ra = cpu_req ? cpu_addr : dma_addr;
	assign hz = pw && ra[31] && (cpu_req ? !cpu_we : dma_req && !dma_we) && ra[18:17] == pa[18:17]
		&& ra[7:1] == pa[7:1] && ra[16:8] != pa[16:8];
	assign gc = cpu_req && !hz;
	assign gd = dma_req && !cpu_req && !hz;
	always @(posedge mclk)
		if (!nrst) begin
			// a write granted at the reset edge still lands in the ram
			if (gc) acc(cpu_we, cpu_addr, cpu_be, cpu_wdata, ecd);
			if (gd) acc(dma_we, dma_addr, dma_be, dma_wdata, edd);
			{pw, phz, pce, pde, pcr, pdr} = '0;
		end else begin
			chk(cpu_ready, gc);
			chk(dma_ready, gd);
			chk(raw_stall, phz);
			chk(cpu_err, pce);
			chk(dma_err, pde);
			chk(cpu_rvalid, pcr);
			chk(dma_rvalid, pdr);
			if (pcr && !$isunknown(ecd)) chk(cpu_rdata, ecd);
			if (pdr && !$isunknown(edd)) chk(dma_rdata, edd);
			{phz, pw} = {hz, 1'b0};
			{pcr, pce} = {gc && !cpu_we && cpu_addr[31], gc && !cpu_addr[31]};
			{pdr, pde} = {gd && !dma_we && dma_addr[31], gd && !dma_addr[31]};
			if (gc) acc(cpu_we, cpu_addr, cpu_be, cpu_wdata, ecd);
			if (gd) acc(dma_we, dma_addr, dma_be, dma_wdata, edd);
		end
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk)
		if (++cyc > 9000) begin
			n_fail++;
			test_done();
		end
	initial begin
		void'($urandom(23));
		repeat (10) @(posedge mclk);
		nrst <= 1;
		repeat (5000) @(posedge mclk);
		nrst <= 0;
		@(posedge mclk);
		nrst <= 1;
		repeat (3000) @(posedge mclk);
		test_done();
	end
endmodule
`default_nettype wire
